// ### inc/ddsc_pkg.sv
package ddsc_pkg;
  // Accumulator and register widths.
  localparam int ACC_W = 28;
  localparam int PH_W = 12;
  localparam int WORD_W = 16;
  localparam int DAC_W = 10;
  // Serial word address field values (top two bits).
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_FREQ_A = 2'h1;
  localparam logic [1:0] ADDR_FREQ_B = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;
  // Control bit positions.
  localparam int BIT_FULL28 = 13;
  localparam int BIT_HIGHHALF = 12;
  localparam int BIT_FREQUENCY_CHOICE_BIT = 11;
  localparam int BIT_PSEL = 10;
  localparam int BIT_SRC = 9;
  localparam int BIT_RESET = 8;
  localparam int BIT_CLKGATE = 7;
  localparam int BIT_DACPD = 6;
  localparam int BIT_SIGNEN = 5;
  localparam int BIT_SIGNSRC = 4;
  localparam int BIT_HALVE = 3;
  localparam int BIT_TRIANGLE = 1;
  // Phase register select bit inside a phase write.
  localparam int BIT_PHSEL = 13;
  // Reset values.
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  localparam logic [27:0] FREQ_RESET = 28'h0000000;
  localparam logic [11:0] PHASE_RESET = 12'h000;
  // Pin-select pipeline delay in master clock cycles.
  localparam int SEL_LATENCY = 8;
  // Decoded control fields carried together.
  typedef struct packed {
    logic freqSel;
    logic phaseSel;
    logic srcPins;
    logic resetBit;
    logic clockGate;
    logic dacPowerdown;
    logic signEnable;
    logic signSource;
    logic halveOff;
    logic triangle;
  } ddsc_ctrl_t;
endpackage

// ### hw/ddsc_sel_pipe.sv
// Delay line that carries the select pins to the datapath.
module ddsc_sel_pipe #(
  parameter int DEPTH = ddsc_pkg::SEL_LATENCY
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire logic [1:0] selIn,
  output logic      [1:0] selOut
);
  // One stage per cycle of latency.
  logic [1:0] stage_reg [DEPTH];

  // Each stage takes the one before it.
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stage
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          stage_reg[gi] <= 2'h0;
        end else if (clkEn) begin
          stage_reg[gi] <= (gi == 0) ? selIn : stage_reg[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // The last stage is the delayed select.
  assign selOut = stage_reg[DEPTH-1];
endmodule

// ### hw/ddsc_wave.sv
// Phase to amplitude: half-cycle parabolic sine approximation or triangle.
module ddsc_wave (
  input  wire logic [11:0] phase,
  input  wire logic        triangle,
  output logic      [9:0]  amp
);
  // Fold the phase into a rise and fall for the triangle.
  wire [10:0] fold = phase[11] ? ~phase[10:0] : phase[10:0];
  // Position inside the half cycle and its distance to the half-cycle end.
  wire [10:0] idx  = phase[10:0];
  wire [10:0] rest = ~phase[10:0];
  // Parabolic lobe idx*(2047-idx), scaled to at most 511, as a sine approximation.
  wire [21:0] prod = idx * rest;
  wire [9:0]  lobe = {1'b0, prod[19:11]};
  // First half of the cycle lies above midscale, second half below, so the MSB is the sign.
  wire [9:0]  sine = phase[11] ? 10'(10'h200 - lobe) : 10'(10'h200 + lobe);
  // Triangle takes the folded phase; sine uses the shaped value.
  assign amp = triangle ? fold[10:1] : sine;
endmodule

// ### hw/ddsc_core.sv
// Control decode, register selection and phase accumulation.
module ddsc_core (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic        wordValid,
  input  wire logic [15:0] wordData,
  input  wire logic        frequency_choice_pin,
  input  wire logic        phase_choice_pin,
  input  wire logic        resetPin,
  input  wire logic        sleepPin,
  input  wire logic        comparatorIn,
  output logic      [9:0]  dacData,
  output logic             dacPowerdown,
  output logic             signOut,
  output logic             signOutEn,
  output logic      [27:0] phaseAccum
);
  // Stored registers.
  logic [13:0] control_word_reg;
  logic [27:0] frequency_word_a_reg;
  logic [27:0] frequency_word_b_reg;
  logic [11:0] phase_offset_a_reg;
  logic [11:0] phase_offset_b_reg;
  logic        lowHalfHeld_reg;
  logic [13:0] lowHalf_reg;
  // Control bits sampled on the falling edge.
  logic [13:0] ctrlFall_reg;
  // Pin synchronisers and outputs.
  logic [3:0]  pinMeta_reg;
  logic [3:0]  pinSync_reg;
  logic [27:0] acc_reg;
  logic [9:0]  dac_reg;
  logic        dacPd_reg;
  logic        sign_reg;
  logic        signEn_reg;
  logic        halfDiv_reg;
  logic        msbPrev_reg;
  logic [1:0]  pinSelDly;

  // Decode of the falling-edge control copy, with triangle taken live.
  ddsc_pkg::ddsc_ctrl_t ctl;
  assign ctl.freqSel      = ctrlFall_reg[ddsc_pkg::BIT_FREQUENCY_CHOICE_BIT];
  assign ctl.phaseSel     = ctrlFall_reg[ddsc_pkg::BIT_PSEL];
  assign ctl.srcPins      = ctrlFall_reg[ddsc_pkg::BIT_SRC];
  assign ctl.resetBit     = ctrlFall_reg[ddsc_pkg::BIT_RESET];
  assign ctl.clockGate    = ctrlFall_reg[ddsc_pkg::BIT_CLKGATE];
  assign ctl.dacPowerdown = ctrlFall_reg[ddsc_pkg::BIT_DACPD];
  assign ctl.signEnable   = ctrlFall_reg[ddsc_pkg::BIT_SIGNEN];
  assign ctl.signSource   = ctrlFall_reg[ddsc_pkg::BIT_SIGNSRC];
  assign ctl.halveOff     = ctrlFall_reg[ddsc_pkg::BIT_HALVE];
  assign ctl.triangle     = control_word_reg[ddsc_pkg::BIT_TRIANGLE];

  // Serial word address decode.
  wire [1:0] addr     = wordData[15:14];
  wire       wrCtrl   = wordValid && (addr == ddsc_pkg::ADDR_CTRL);
  wire       wrFreqA  = wordValid && (addr == ddsc_pkg::ADDR_FREQ_A);
  wire       wrFreqB  = wordValid && (addr == ddsc_pkg::ADDR_FREQ_B);
  wire       wrPhase  = wordValid && (addr == ddsc_pkg::ADDR_PHASE);
  wire       full28   = control_word_reg[ddsc_pkg::BIT_FULL28];
  wire       highHalf = control_word_reg[ddsc_pkg::BIT_HIGHHALF];

  // Merge of a 14-bit half into a frequency word.
  function automatic logic [27:0] mergeFreq(input logic [27:0] old, input logic [13:0] d,
                                            input logic full, input logic held,
                                            input logic [13:0] lo, input logic hi);
    if (full) begin
      mergeFreq = held ? {d, lo} : old;
    end else begin
      mergeFreq = hi ? {d, old[13:0]} : {old[27:14], d};
    end
  endfunction

  // Register loads; the control word keeps reserved bits as written.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      control_word_reg     <= ddsc_pkg::CTRL_RESET;
      frequency_word_a_reg <= ddsc_pkg::FREQ_RESET;
      frequency_word_b_reg <= ddsc_pkg::FREQ_RESET;
      phase_offset_a_reg   <= ddsc_pkg::PHASE_RESET;
      phase_offset_b_reg   <= ddsc_pkg::PHASE_RESET;
      lowHalfHeld_reg      <= 1'b0;
      lowHalf_reg          <= 14'h0000;
    end else if (clkEn) begin
      if (wrCtrl) begin
        control_word_reg <= wordData[13:0];
        lowHalfHeld_reg  <= 1'b0;
      end
      if (wrFreqA) begin
        frequency_word_a_reg <= mergeFreq(frequency_word_a_reg, wordData[13:0], full28, lowHalfHeld_reg,
                                          lowHalf_reg, highHalf);
      end
      if (wrFreqB) begin
        frequency_word_b_reg <= mergeFreq(frequency_word_b_reg, wordData[13:0], full28, lowHalfHeld_reg,
                                          lowHalf_reg, highHalf);
      end
      // In full-word mode the first half is parked until the second arrives.
      if ((wrFreqA || wrFreqB) && full28) begin
        lowHalfHeld_reg <= ~lowHalfHeld_reg;
        lowHalf_reg     <= wordData[13:0];
      end
      if (wrPhase && !wordData[ddsc_pkg::BIT_PHSEL]) begin
        phase_offset_a_reg <= wordData[11:0];
      end
      if (wrPhase && wordData[ddsc_pkg::BIT_PHSEL]) begin
        phase_offset_b_reg <= wordData[11:0];
      end
    end
  end

  // Control bits cross onto the falling edge before use, except triangle, full28 and highHalf.
  always_ff @(negedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlFall_reg <= ddsc_pkg::CTRL_RESET;
    end else if (clkEn) begin
      ctrlFall_reg <= control_word_reg;
    end
  end

  // Two-flop synchroniser for the four pins.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_reg <= 4'h0;
      pinSync_reg <= 4'h0;
    end else if (clkEn) begin
      pinMeta_reg <= {frequency_choice_pin, phase_choice_pin, resetPin, sleepPin};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Select pins travel through the latency line.
  ddsc_sel_pipe #(
    .DEPTH(ddsc_pkg::SEL_LATENCY - 2)
  ) u_pipe (
    .sys_clk(sys_clk),
    .rstn   (rstn),
    .clkEn  (clkEn),
    .selIn  (pinSync_reg[3:2]),
    .selOut (pinSelDly)
  );

  // Source choice between pins and bits.
  wire frequency_choice_bit      = ctl.srcPins ? pinSelDly[1] : ctl.freqSel;
  wire pSel      = ctl.srcPins ? pinSelDly[0] : ctl.phaseSel;
  wire dpReset   = ctl.srcPins ? pinSync_reg[1] : ctl.resetBit;
  wire dacPdNext = ctl.srcPins ? pinSync_reg[0] : ctl.dacPowerdown;
  wire [27:0] selFreq  = frequency_choice_bit ? frequency_word_b_reg : frequency_word_a_reg;
  wire [11:0] selPhase = pSel ? phase_offset_b_reg : phase_offset_a_reg;
  // Offset lands on the top bits, sum wraps at the accumulator width.
  wire [27:0] phaseSum = acc_reg + {selPhase, 16'h0000};
  wire [9:0]  ampWave;
  wire        runClk   = !ctl.clockGate;

  ddsc_wave u_wave (
    .phase   (phaseSum[27:16]),
    .triangle(ctl.triangle),
    .amp     (ampWave)
  );

  // Accumulator, DAC word and sign output.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg     <= 28'h0000000;
      dac_reg     <= 10'h200;
      dacPd_reg   <= 1'b0;
      sign_reg    <= 1'b0;
      signEn_reg  <= 1'b0;
      halfDiv_reg <= 1'b0;
      msbPrev_reg <= 1'b0;
    end else if (clkEn) begin
      dacPd_reg  <= dacPdNext;
      signEn_reg <= ctl.signEnable;
      if (dpReset) begin
        acc_reg     <= 28'h0000000;
        dac_reg     <= 10'h200;
        halfDiv_reg <= 1'b0;
        msbPrev_reg <= 1'b0;
      end else if (runClk) begin
        acc_reg     <= 28'(acc_reg + selFreq);
        dac_reg     <= ampWave;
        msbPrev_reg <= dac_reg[9];
        if (dac_reg[9] && !msbPrev_reg) begin
          halfDiv_reg <= ~halfDiv_reg;
        end
      end
      // Comparator or DAC MSB, halved or not.
      sign_reg <= ctl.signSource ? comparatorIn : (ctl.halveOff ? dac_reg[9] : halfDiv_reg);
    end
  end

  assign dacData      = dac_reg;
  assign dacPowerdown = dacPd_reg;
  assign signOut      = sign_reg;
  assign signOutEn    = signEn_reg;
  assign phaseAccum   = acc_reg;

  // Checks.
  sequence sResetSeen;
    dpReset ##1 1'b1;
  endsequence
  AST_RESET_MID: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && dpReset |=> dac_reg == 10'h200 && acc_reg == 28'h0)
    else $error("datapath not cleared");
  AST_GATE_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && !dpReset && ctl.clockGate |=> $stable(acc_reg))
    else $error("accumulator moved while gated");
  AST_ACC_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && !dpReset && runClk |=> acc_reg == 28'($past(acc_reg) + $past(selFreq)))
    else $error("accumulator step wrong");
  AST_PD_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn |=> dacPowerdown == $past(dacPdNext))
    else $error("powerdown not following");
  AST_SIGN_EN: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn |=> signOutEn == $past(ctl.signEnable))
    else $error("sign enable wrong");
  AST_SIGN_CMP: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && ctl.signSource |=> signOut == $past(comparatorIn))
    else $error("sign not from comparator");
  AST_FREQUENCY_CHOICE_BIT_SW: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ctl.srcPins && !ctl.freqSel |-> selFreq == frequency_word_a_reg)
    else $error("wrong frequency word");
  AST_PSEL_SW: assert property (@(posedge sys_clk) disable iff (!rstn)
    !ctl.srcPins && ctl.phaseSel |-> selPhase == phase_offset_b_reg)
    else $error("wrong phase offset");
  AST_CTRL_WR: assert property (@(posedge sys_clk) disable iff (!rstn)
    clkEn && wrCtrl |=> control_word_reg == $past(wordData[13:0]))
    else $error("control write lost");
  AST_SUM_ALIGN: assert property (@(posedge sys_clk) disable iff (!rstn)
    phaseSum[15:0] == acc_reg[15:0])
    else $error("offset misaligned");
endmodule

// ### bench/ddsc_host_model.sv
// Behavioural host that writes 16-bit serial words into the control and data registers.
module ddsc_host_model (
  input  wire logic        sys_clk,
  output logic             wordValid,
  output logic      [15:0] wordData
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    wordValid = 1'b0;
    wordData  = 16'h0000;
  end

  // One word per call; callers keep the reserved control bits 0 and 2 zero.
  task automatic sendWord(input logic [15:0] w);
    @(posedge sys_clk);
    wordValid <= 1'b1;
    wordData  <= w;
    @(posedge sys_clk);
    wordValid <= 1'b0;
    // A released bus shows the inverse, so stale data can never pass for a fresh word.
    wordData  <= ~w;
  endtask
endmodule

// ### bench/ddsc_core_tb.sv
// Self-checking bench for control decode and register selection.
module ddsc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;       // Master clock, 40 ns period.
  logic        rstn;          // Asynchronous reset, active low.
  logic        clkEn;         // Clock enable, high except during the s_pins freeze.
  logic        fPin;          // Frequency choice pin.
  logic        pPin;          // Phase choice pin, held steady under software selection.
  logic        resetPin;      // Pin-driven internal reset.
  logic        sleepPin;      // Pin-driven DAC power-down.
  logic        comparatorIn;  // Comparator result.
  logic        wordValid;     // Word strobe from the host.
  logic [15:0] wordData;      // Word from the host.
  logic [9:0]  dacData;       // DAC word.
  logic        dacPowerdown;  // DAC off flag.
  logic        signOut;       // Sign pin value.
  logic        signOutEn;     // Sign pin enable.
  logic [27:0] phaseAccum;    // Accumulator.
  int          miscompares;   // Mismatch count.
  int          checked;       // Comparison count.

  ddsc_host_model host (.sys_clk(sys_clk), .wordValid(wordValid), .wordData(wordData));

  ddsc_core uut (
    .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .wordValid(wordValid), .wordData(wordData),
    .frequency_choice_pin(fPin), .phase_choice_pin(pPin), .resetPin(resetPin), .sleepPin(sleepPin),
    .comparatorIn(comparatorIn), .dacData(dacData), .dacPowerdown(dacPowerdown), .signOut(signOut),
    .signOutEn(signOutEn), .phaseAccum(phaseAccum)
  );

  // Clock generator.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compares one value against its expectation and counts the result.
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops.
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits a number of clock cycles and then lets outputs settle.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Measures the accumulator advance over ten cycles once the selection has settled.
  task automatic rate(input logic [27:0] step);
    logic [27:0] a;
    cyc(12);
    a = phaseAccum;
    cyc(10);
    check(phaseAccum - a, 28'(step * 10));
  endtask

  // Counts rising edges of the sign pin over 256 cycles.
  task automatic rises(output int n);
    logic prev;
    n = 0;
    prev = signOut;
    repeat (256) begin
      cyc(1);
      if (signOut === 1'b1 && prev === 1'b0) n++;
      prev = signOut;
    end
  endtask

  // State straight after reset.
  task automatic s_reset();
    check(dacData, 28'h200);
    check(phaseAccum, 28'h0);
    check(signOutEn, 28'h0);
    check(dacPowerdown, 28'h0);
  endtask

  // Two frequency words chosen by bit and then by pin, source switched on the fly.
  task automatic s_freq();
    host.sendWord(16'h0000);
    host.sendWord(16'h4005);
    host.sendWord(16'h8003);
    rate(28'h5);
    host.sendWord(16'h0800);
    rate(28'h3);
    host.sendWord(16'h0200);
    rate(28'h5);
    fPin <= 1'b1;
    rate(28'h3);
    host.sendWord(16'h0000);
    rate(28'h5);
    fPin <= 1'b0;
    host.sendWord(16'h0A00);
    rate(28'h5);
  endtask

  // Pin-driven reset and power-down under pin control, then the control bits.
  task automatic s_ctrl();
    logic [27:0] a;
    resetPin <= 1'b1;
    cyc(5);
    check(phaseAccum, 28'h0);
    check(dacData, 28'h200);
    resetPin <= 1'b0;
    sleepPin <= 1'b1;
    cyc(5);
    check(dacPowerdown, 28'h1);
    sleepPin <= 1'b0;
    host.sendWord(16'h0100);
    cyc(3);
    check(phaseAccum, 28'h0);
    check(dacData, 28'h200);
    host.sendWord(16'h0080);
    cyc(3);
    a = {dacData, 18'h0} | 28'(phaseAccum[17:0]);
    cyc(10);
    check({dacData, 18'h0} | 28'(phaseAccum[17:0]), a);
    host.sendWord(16'h0040);
    cyc(3);
    check(dacPowerdown, 28'h1);
    host.sendWord(16'h0000);
    cyc(3);
    check(dacPowerdown, 28'h0);
  endtask

  // Sign pin: comparator path, enable, direct and halved MSB.
  task automatic s_sign();
    int n;
    host.sendWord(16'h0030);
    comparatorIn <= 1'b1;
    cyc(3);
    check(signOutEn, 28'h1);
    check(signOut, 28'h1);
    comparatorIn <= 1'b0;
    cyc(3);
    check(signOut, 28'h0);
    host.sendWord(16'h0000);
    cyc(3);
    check(signOutEn, 28'h0);
    host.sendWord(16'h2000);
    host.sendWord(16'h4000);
    host.sendWord(16'h4400);
    host.sendWord(16'h0028);
    cyc(4);
    rises(n);
    check(n >= 15 && n <= 17, 28'h1);
    host.sendWord(16'h0020);
    cyc(4);
    rises(n);
    check(n >= 7 && n <= 9, 28'h1);
  endtask

  // Phase offsets at a frozen zero accumulator, sine against triangle.
  task automatic s_phase();
    logic [9:0] sine;
    host.sendWord(16'h2000);
    host.sendWord(16'h4000);
    host.sendWord(16'h4000);
    host.sendWord(16'h0100);
    host.sendWord(16'h0000);
    host.sendWord(16'hC400);
    host.sendWord(16'hEC00);
    cyc(4);
    check(phaseAccum, 28'h0);
    check(dacData[9], 28'h1);
    sine = dacData;
    host.sendWord(16'h0002);
    cyc(4);
    check(dacData !== sine, 28'h1);
    host.sendWord(16'h0400);
    cyc(4);
    check(dacData[9], 28'h0);
  endtask

  // Phase choice pin under pin control, then a clock-enable freeze of the accumulator.
  task automatic s_pins();
    logic [27:0] a;
    host.sendWord(16'h0200);
    cyc(12);
    check(dacData[9], 28'h1);
    pPin <= 1'b1;
    cyc(12);
    check(dacData[9], 28'h0);
    host.sendWord(16'h0000);
    host.sendWord(16'h4005);
    cyc(4);
    clkEn <= 1'b0;
    a = phaseAccum;
    cyc(10);
    check(phaseAccum, a);
    clkEn <= 1'b1;
    cyc(10);
    check(phaseAccum != a, 28'h1);
  endtask

  // Main sequence.
  initial begin
    miscompares = 0;
    checked = 0;
    rstn = 1'b0;
    clkEn = 1'b1;
    fPin = 1'b0;
    pPin = 1'b0;
    resetPin = 1'b0;
    sleepPin = 1'b0;
    comparatorIn = 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(1);
    s_reset();
    s_freq();
    s_ctrl();
    s_sign();
    s_phase();
    s_pins();
    tally_and_finish();
  end

  // Watchdog against a hang.
  initial begin
    #2ms;
    miscompares++;
    tally_and_finish();
  end
endmodule
